// File: design/uaux_pkg.sv
// Purpose: shared constants for the uart auxiliary channel block
// Assumes: control registers are held outside and arrive as plain ports
// Notes: bit positions are within the 8-bit control bytes
package uaux_pkg;
  // modem control byte fields
  localparam int MCTL_TERM_READY_BIT = 0;
  localparam int MCTL_REQ_SEND_BIT = 1;
  localparam int MCTL_USER_ONE_BIT = 2;
  localparam int MCTL_USER_TWO_BIT = 3;
  localparam int MCTL_LOOP_BIT = 4;
  localparam int MCTL_CLK_SEL_BIT = 7;
  // fifo control byte fields
  localparam int FCTL_FIFO_EN_BIT = 0;
  localparam int FCTL_DMA_MODE_BIT = 3;
  // interrupt enable byte fields
  localparam int IEN_RX_BIT = 0;
  localparam int IEN_TX_BIT = 1;
  localparam int IEN_MODEM_BIT = 3;
  localparam int IEN_SLEEP_BIT = 4;
  // enhanced feature byte field
  localparam int EFEAT_ENH_BIT = 4;
  // timing counts
  localparam int TICKS_PER_BIT = 16;
  localparam int PRESCALE_DIV = 4;
  localparam int FIFO_DEPTH = 64;
  // reset values
  localparam logic [7:0] MSTAT_RESET = 8'h00;
  // sleep controller states
  typedef enum logic [0:0] {
    UAUX_AWAKE = 1'b0,
    UAUX_ASLEEP = 1'b1
  } uaux_sleep_t;
endpackage

// File: design/uaux_baud_gen.sv
// Purpose: prescaler and 16-bit divisor making the 16x tick
// Assumes: divisor is stable while run_i is high
// Notes: a divisor of zero holds the generator stopped
`timescale 1ns/1ns
module uaux_baud_gen #(
  parameter int DIV_W = 16
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire logic by4_i,
  input wire logic [DIV_W-1:0] divisor_i,
  output logic tick16_o
);
  import uaux_pkg::*;
  logic [1:0] pre_cnt;
  logic [1:0] next_pre_cnt;
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic next_tick16;
  logic pre_pulse;

  ////////////////////////////////////////////////////////////////////
  // prescale by 1 or 4, then divide by the programmed divisor
  always_comb begin
    next_pre_cnt = pre_cnt;
    next_div_cnt = div_cnt;
    next_tick16 = 1'b0;
    pre_pulse = 1'b0;
    if (run_i && divisor_i != '0) begin
      if (!by4_i || pre_cnt == 2'(PRESCALE_DIV - 1)) begin
        pre_pulse = 1'b1;
        next_pre_cnt = 2'h0;
      end else begin
        next_pre_cnt = pre_cnt + 2'h1;
      end
      // any divisor 1..65535 works: count 0..divisor-1
      if (pre_pulse) begin
        if (div_cnt >= divisor_i - 1'b1) begin
          next_div_cnt = '0;
          next_tick16 = 1'b1;
        end else begin
          next_div_cnt = div_cnt + 1'b1;
        end
      end
    end else begin
      next_pre_cnt = 2'h0;
      next_div_cnt = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      pre_cnt <= 2'h0;
      div_cnt <= '0;
      tick16_o <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      div_cnt <= next_div_cnt;
      tick16_o <= next_tick16;
    end
  end
endmodule

// File: design/uaux_bit_timer.sv
// Purpose: divides the 16x tick down to one pulse per serial bit
// Assumes: tick16_i is a one-cycle pulse
// Notes: clear_i realigns the phase, e.g. on a start bit
`timescale 1ns/1ns
module uaux_bit_timer (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic tick16_i,
  input wire logic clear_i,
  output logic bit_tick_o
);
  import uaux_pkg::*;
  logic [3:0] phase;
  logic [3:0] next_phase;
  logic next_bit_tick;

  ////////////////////////////////////////////////////////////////////
  // sixteen 16x ticks make one bit time
  always_comb begin
    next_phase = phase;
    next_bit_tick = 1'b0;
    if (clear_i) begin
      next_phase = 4'h0;
    end else if (tick16_i) begin
      next_phase = phase + 4'h1;
      next_bit_tick = (phase == 4'(TICKS_PER_BIT - 1));
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      phase <= 4'h0;
      bit_tick_o <= 1'b0;
    end else begin
      phase <= next_phase;
      bit_tick_o <= next_bit_tick;
    end
  end
endmodule

// File: design/uaux_channel.sv
// Purpose: baud generation, dma signalling, sleep and loop-back of one channel
// Assumes: control bytes are held by the register file outside this block
// Notes: all outputs are registered, so pins follow controls by one clock, the loop bit by two
`timescale 1ns/1ns

// Function
// - divisor of one to 65535 divides the 16x clock source
// - each serial bit spans sixteen 16x ticks
// - after reset the rate table pin picks the 1x or 4x table
// - clock select bit with pin high adds divide by four, else by one
// - divisor is a high byte and a low byte from the host
// - one generator feeds both transmitter and receiver
// - fifo control bit picks dma mode 0 or mode 1
// - mode 0 with fifos on raises interrupt per character
// - mode 1 interrupts on tx below trigger or rx above trigger
// - status shows tx holding room and transmitter fully empty
// - sleep only when enhanced enable and sleep enable are both set
// - wake on start bit, input level change or host tx write
// - after waking, sleep again once last character sent and last one read
// - never enter sleep while an interrupt is pending
// - sleep stays enabled until host clears the sleep enable bit
// - loop-back disconnects modem pins, low control bits drive them
// - loop-back ties transmitter output straight to receiver input
// - loop-back: user output one to ring, two to carrier detect
// - loop-back: terminal ready to clear-to-send, request to set-ready
// - looped test bytes go out and return through the receiver
// - interrupts stay working in loop-back, gated by enables
// - loop-back modem causes read via change bits only
module uaux_channel #(
  parameter int DIV_W = 16,
  parameter int CNT_W = 7
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  // straps and control bytes from the register file
  input wire logic rate_table_pin_i,
  input wire logic [7:0] divisor_high_i,
  input wire logic [7:0] divisor_low_i,
  input wire logic [7:0] modem_control_reg_i,
  input wire logic [7:0] fifo_control_reg_i,
  input wire logic [7:0] interrupt_enable_reg_i,
  input wire logic [7:0] enhanced_feature_reg_i,
  // fifo and core state
  input wire logic [CNT_W-1:0] tx_count_i,
  input wire logic [CNT_W-1:0] rx_count_i,
  input wire logic [CNT_W-1:0] tx_trigger_i,
  input wire logic [CNT_W-1:0] rx_trigger_i,
  input wire logic tx_busy_i,
  input wire logic tx_write_i,
  input wire logic rx_read_i,
  input wire logic start_bit_i,
  input wire logic other_irq_i,
  input wire logic modem_status_read_i,
  input wire logic core_tx_serial_i,
  // serial and modem pins, modem pins active low
  input wire logic rx_pin_i,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic carrier_detect_in_n_i,
  input wire logic bell_input_n_i,
  output logic tx_pin_o,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic user_output_one_n_o,
  output logic user_output_two_n_o,
  // towards the transmitter and receiver core
  output logic core_rx_serial_o,
  output logic tick16_o,
  output logic bit_tick_o,
  output logic [7:0] modem_status_reg_o,
  output logic [6:5] line_status_reg_o,
  output logic irq_o,
  output logic sleeping_o
);
  import uaux_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // declarations
  logic strap_done;
  logic next_strap_done;
  logic table_1x;
  logic next_table_1x;
  logic by4;
  logic [DIV_W-1:0] divisor;
  logic gen_tick16;
  logic gen_bit_tick;
  logic loop_on;
  logic next_loop_on;
  logic [3:0] mlev;
  logic [3:0] next_mlev;
  logic [3:0] mdelta;
  logic [3:0] next_mdelta;
  logic [3:0] mlev_now;
  logic rx_prev;
  logic next_rx_prev;
  logic [3:0] pin_prev;
  logic [3:0] next_pin_prev;
  logic next_tx_pin;
  logic next_rts_n;
  logic next_dtr_n;
  logic next_op1_n;
  logic next_op2_n;
  logic next_core_rx;
  logic [7:0] next_mstat;
  logic [6:5] next_lstat;
  logic next_irq;
  logic rx_irq;
  logic tx_irq;
  logic modem_irq;
  logic irq_cond;
  logic sleep_en;
  logic chan_idle;
  logic wake_evt;
  uaux_sleep_t sleep_state;
  uaux_sleep_t next_sleep_state;
  logic next_sleeping;

  ////////////////////////////////////////////////////////////////////
  // rate table strap, caught the clock after reset release
  always_comb begin
    next_strap_done = 1'b1;
    next_table_1x = table_1x;
    if (!strap_done) begin
      next_table_1x = rate_table_pin_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      strap_done <= 1'b0;
      table_1x <= 1'b1;
    end else begin
      strap_done <= next_strap_done;
      table_1x <= next_table_1x;
    end
  end

  // pin low keeps the 4x table; only a high strap hands it to software
  assign by4 = table_1x ? modem_control_reg_i[MCTL_CLK_SEL_BIT] : 1'b1;
  assign divisor = {divisor_high_i, divisor_low_i};

  ////////////////////////////////////////////////////////////////////
  // one generator for both directions; it stops while asleep
  uaux_baud_gen #(
    .DIV_W(DIV_W)
  ) u_gen (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .run_i(!sleeping_o),
    .by4_i(by4),
    .divisor_i(divisor),
    .tick16_o(gen_tick16)
  );

  uaux_bit_timer u_bit (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .tick16_i(gen_tick16),
    .clear_i(sleeping_o),
    .bit_tick_o(gen_bit_tick)
  );

  ////////////////////////////////////////////////////////////////////
  // loop-back select, registered so every pin swaps together
  always_comb begin
    next_loop_on = modem_control_reg_i[MCTL_LOOP_BIT];
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      loop_on <= 1'b0;
    end else begin
      loop_on <= next_loop_on;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // internal modem levels: [0] cts, [1] dsr, [2] ring, [3] carrier
  always_comb begin
    if (loop_on) begin
      mlev_now[0] = modem_control_reg_i[MCTL_TERM_READY_BIT];
      mlev_now[1] = modem_control_reg_i[MCTL_REQ_SEND_BIT];
      mlev_now[2] = modem_control_reg_i[MCTL_USER_ONE_BIT];
      mlev_now[3] = modem_control_reg_i[MCTL_USER_TWO_BIT];
    end else begin
      mlev_now = ~{carrier_detect_in_n_i, bell_input_n_i, dsr_n_i, cts_n_i};
    end
  end

  // change bits are sticky; a change in the read cycle survives it
  always_comb begin
    next_mlev = mlev_now;
    next_mdelta = mdelta;
    if (modem_status_read_i) begin
      next_mdelta = 4'h0;
    end
    next_mdelta = next_mdelta | (mlev_now ^ mlev);
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      mlev <= 4'h0;
      mdelta <= 4'h0;
    end else begin
      mlev <= next_mlev;
      mdelta <= next_mdelta;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin steering: looped pins park inactive, serial is tied inside
  always_comb begin
    if (loop_on) begin
      next_tx_pin = 1'b1;
      next_core_rx = core_tx_serial_i;
      next_dtr_n = 1'b1;
      next_rts_n = 1'b1;
      next_op1_n = 1'b1;
      next_op2_n = 1'b1;
    end else begin
      next_tx_pin = core_tx_serial_i;
      next_core_rx = rx_pin_i;
      next_dtr_n = !modem_control_reg_i[MCTL_TERM_READY_BIT];
      next_rts_n = !modem_control_reg_i[MCTL_REQ_SEND_BIT];
      next_op1_n = !modem_control_reg_i[MCTL_USER_ONE_BIT];
      next_op2_n = !modem_control_reg_i[MCTL_USER_TWO_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt conditions, per character or per trigger level
  always_comb begin
    rx_irq = 1'b0;
    tx_irq = 1'b0;
    if (fifo_control_reg_i[FCTL_FIFO_EN_BIT]
        && fifo_control_reg_i[FCTL_DMA_MODE_BIT]) begin
      rx_irq = rx_count_i > rx_trigger_i;
      tx_irq = tx_count_i < tx_trigger_i;
    end else begin
      rx_irq = rx_count_i != '0;
      tx_irq = tx_count_i == '0;
    end
    rx_irq = rx_irq && interrupt_enable_reg_i[IEN_RX_BIT];
    tx_irq = tx_irq && interrupt_enable_reg_i[IEN_TX_BIT];
    modem_irq = (mdelta != 4'h0) && interrupt_enable_reg_i[IEN_MODEM_BIT];
    irq_cond = rx_irq || tx_irq || modem_irq || other_irq_i;
  end

  ////////////////////////////////////////////////////////////////////
  // status outputs; upper modem bits blank while looped back
  always_comb begin
    next_irq = irq_cond;
    next_mstat = {mlev, mdelta};
    if (loop_on) begin
      next_mstat = {4'h0, mdelta};
    end
    if (fifo_control_reg_i[FCTL_FIFO_EN_BIT]) begin
      next_lstat[5] = tx_count_i < CNT_W'(FIFO_DEPTH);
    end else begin
      next_lstat[5] = tx_count_i == '0;
    end
    next_lstat[6] = (tx_count_i == '0) && !tx_busy_i;
  end

  ////////////////////////////////////////////////////////////////////
  // sleep controller; pin wake sources are edges seen on raw inputs
  always_comb begin
    next_rx_prev = rx_pin_i;
    next_pin_prev = {carrier_detect_in_n_i, bell_input_n_i, dsr_n_i, cts_n_i};
    sleep_en = enhanced_feature_reg_i[EFEAT_ENH_BIT]
               && interrupt_enable_reg_i[IEN_SLEEP_BIT];
    // idle means the last character is out and the last one read
    chan_idle = (tx_count_i == '0) && !tx_busy_i && (rx_count_i == '0);
    wake_evt = start_bit_i || tx_write_i || rx_read_i
               || (rx_pin_i != rx_prev)
               || (next_pin_prev != pin_prev);
    next_sleep_state = sleep_state;
    case (sleep_state)
      UAUX_AWAKE: begin
        // re-entry is automatic while enable stays set
        if (sleep_en && chan_idle && !irq_cond && !wake_evt) begin
          next_sleep_state = UAUX_ASLEEP;
        end
      end
      UAUX_ASLEEP: begin
        if (!sleep_en || wake_evt || irq_cond) begin
          next_sleep_state = UAUX_AWAKE;
        end
      end
      default: begin
        next_sleep_state = UAUX_AWAKE;
      end
    endcase
    next_sleeping = next_sleep_state == UAUX_ASLEEP;
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      sleep_state <= UAUX_AWAKE;
      rx_prev <= 1'b1;
      pin_prev <= 4'hf;
    end else begin
      sleep_state <= next_sleep_state;
      rx_prev <= next_rx_prev;
      pin_prev <= next_pin_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output register stage; costs a clock but keeps pins glitch free
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      tx_pin_o <= 1'b1;
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
      user_output_one_n_o <= 1'b1;
      user_output_two_n_o <= 1'b1;
      core_rx_serial_o <= 1'b1;
      tick16_o <= 1'b0;
      bit_tick_o <= 1'b0;
      modem_status_reg_o <= MSTAT_RESET;
      line_status_reg_o <= 2'b11;
      irq_o <= 1'b0;
      sleeping_o <= 1'b0;
    end else begin
      tx_pin_o <= next_tx_pin;
      rts_n_o <= next_rts_n;
      dtr_n_o <= next_dtr_n;
      user_output_one_n_o <= next_op1_n;
      user_output_two_n_o <= next_op2_n;
      core_rx_serial_o <= next_core_rx;
      tick16_o <= gen_tick16;
      bit_tick_o <= gen_bit_tick;
      modem_status_reg_o <= next_mstat;
      line_status_reg_o <= next_lstat;
      irq_o <= next_irq;
      sleeping_o <= next_sleeping;
    end
  end
endmodule

// File: dv/uaux_channel_properties.sv
// Purpose: port checks for uaux_channel
// Assumes: one clock, sync active-low reset
// Notes: pin checks wait until controls have settled
`timescale 1ns/1ns
////////////////////////////////////////
module uaux_channel_chk #(
  parameter int DIV_W = 16,
  parameter int CNT_W = 7
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [7:0] divisor_high_i,
  input wire logic [7:0] divisor_low_i,
  input wire logic [7:0] modem_control_reg_i,
  input wire logic [7:0] fifo_control_reg_i,
  input wire logic [7:0] interrupt_enable_reg_i,
  input wire logic [7:0] enhanced_feature_reg_i,
  input wire logic [CNT_W-1:0] rx_count_i,
  input wire logic [CNT_W-1:0] rx_trigger_i,
  input wire logic tx_write_i,
  input wire logic other_irq_i,
  input wire logic core_tx_serial_i,
  input wire logic tx_pin_o,
  input wire logic rts_n_o,
  input wire logic dtr_n_o,
  input wire logic user_output_one_n_o,
  input wire logic user_output_two_n_o,
  input wire logic core_rx_serial_o,
  input wire logic tick16_o,
  input wire logic bit_tick_o,
  input wire logic [7:0] modem_status_reg_o,
  input wire logic irq_o,
  input wire logic sleeping_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] mc;
  assign mc = modem_control_reg_i;
  // loop-back takes two edges to settle, so wait four
  sequence loop_held; (mc[4]) [*4]; endsequence
  sequence plain_held; (!mc[4]) [*4]; endsequence
  sequence tx_settled; $past(core_tx_serial_i) == $past(core_tx_serial_i, 2); endsequence
  ////////////////////////////////////////
  loop_wire_a: assert property (loop_held ##0 tx_settled |->
    core_rx_serial_o == $past(core_tx_serial_i)) else $error("looped serial differs");
  loop_park_a: assert property (loop_held |-> tx_pin_o && rts_n_o && dtr_n_o &&
    user_output_one_n_o && user_output_two_n_o && modem_status_reg_o[7:4] == 4'h0)
    else $error("pins not parked in loop-back");
  plain_ctl_a: assert property (plain_held ##0 $stable(mc) |-> rts_n_o == !mc[1] &&
    dtr_n_o == !mc[0] && user_output_one_n_o == !mc[2]) else $error("modem outputs wrong");
  loop_cts_a: assert property (loop_held ##0 $rose(mc[0]) |->
    ##[1:4] modem_status_reg_o[0]) else $error("looped clear-to-send change lost");
  div_stop_a: assert property (({divisor_high_i, divisor_low_i} == 16'h0000) [*3] |->
    !tick16_o) else $error("tick with zero divisor");
  bit_gap_a: assert property (bit_tick_o |=> (!bit_tick_o) [*8])
    else $error("bit ticks too close");
  dma_one_a: assert property (fifo_control_reg_i[0] && fifo_control_reg_i[3] &&
    interrupt_enable_reg_i[0] && rx_count_i > rx_trigger_i |=> irq_o) else $error("no rx irq");
  sleep_gate_a: assert property (sleeping_o |-> $past(enhanced_feature_reg_i[4]) &&
    $past(interrupt_enable_reg_i[4])) else $error("asleep without both enables");
  write_wake_a: assert property (sleeping_o && tx_write_i |=> !sleeping_o)
    else $error("tx write did not wake");
  irq_nosleep_a: assert property ($rose(sleeping_o) |-> !$past(other_irq_i))
    else $error("slept with irq pending");
endmodule
////////////////////////////////////////
bind uaux_channel uaux_channel_chk #(.DIV_W(DIV_W), .CNT_W(CNT_W)) i_chk (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .divisor_high_i(divisor_high_i),
  .divisor_low_i(divisor_low_i), .modem_control_reg_i(modem_control_reg_i),
  .fifo_control_reg_i(fifo_control_reg_i), .interrupt_enable_reg_i(interrupt_enable_reg_i),
  .enhanced_feature_reg_i(enhanced_feature_reg_i), .rx_count_i(rx_count_i),
  .rx_trigger_i(rx_trigger_i), .tx_write_i(tx_write_i), .other_irq_i(other_irq_i),
  .core_tx_serial_i(core_tx_serial_i), .tx_pin_o(tx_pin_o), .rts_n_o(rts_n_o),
  .dtr_n_o(dtr_n_o), .user_output_one_n_o(user_output_one_n_o),
  .user_output_two_n_o(user_output_two_n_o), .core_rx_serial_o(core_rx_serial_o),
  .tick16_o(tick16_o), .bit_tick_o(bit_tick_o), .modem_status_reg_o(modem_status_reg_o),
  .irq_o(irq_o), .sleeping_o(sleeping_o));

// File: dv/uaux_remote.sv
// Purpose: remote serial device on line and modem pins
// Assumes: modem pins active low, line idles high
// Notes: BIT_CLKS picks a prompt or slow sender
`timescale 1ns/1ns
module uaux_remote #(
  parameter int BIT_CLKS = 4
) (
  input wire logic clock_i,
  input wire logic send_i,
  input wire logic [7:0] byte_i,
  input wire logic [3:0] modem_i,
  output logic rx_pin_o,
  output logic [3:0] modem_n_o,
  output logic busy_o
);
  logic [9:0] frame;
  initial begin
    rx_pin_o = 1'b1;
    modem_n_o = 4'hf;
    busy_o = 1'b0;
  end
  ////////////////////////////////////////
  // modem levels move only on an edge
  always @(posedge clock_i) modem_n_o <= ~modem_i;
  // start low, data lsb first, stop high
  always begin
    @(posedge clock_i);
    if (send_i) begin
      busy_o <= 1'b1;
      frame = {1'b1, byte_i, 1'b0};
      for (int i = 0; i < 10; i++) begin
        rx_pin_o <= frame[i];
        repeat (BIT_CLKS) @(posedge clock_i);
      end
      busy_o <= 1'b0;
    end
  end
endmodule

// File: dv/test_uaux_channel.sv
// Purpose: self-checking bench for uaux_channel
// Assumes: inputs change by nba at the rising edge
// Notes: outputs are read at the falling edge
`timescale 1ns/1ns
module test_uaux_channel;
  import uaux_pkg::*;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic pin = 1'b1, twr = 1'b0, sbit = 1'b0, oirq = 1'b0, mrd = 1'b0, ctx = 1'b1;
  logic busy = 1'b0, send = 1'b0, rrd = 1'b0;
  logic [7:0] dh = 8'h00, dl = 8'h03, modem_control_reg = 8'h00, fifo_control_reg = 8'h00, interrupt_enable_reg = 8'h00, enhanced_feature_reg = 8'h00;
  logic [6:0] txc = 7'h00, rxc = 7'h00, txt = 7'h00, rxt = 7'h00;
  logic [3:0] mdm = 4'h0;
  logic [3:0] mdm_n;
  logic rxp, txp, rts_n, dtr_n, u1_n, u2_n, crx, t16, btk, irq, slp, rbusy;
  logic [7:0] modem_status_reg;
  logic [6:5] line_status_reg;
  int n_errors = 0;
  int checks_done = 0;
  always #10 clock_i = ~clock_i;
  ////////////////////////////////////////
  uaux_channel i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .rate_table_pin_i(pin),
    .divisor_high_i(dh), .divisor_low_i(dl), .modem_control_reg_i(modem_control_reg),
    .fifo_control_reg_i(fifo_control_reg), .interrupt_enable_reg_i(interrupt_enable_reg), .enhanced_feature_reg_i(enhanced_feature_reg),
    .tx_count_i(txc), .rx_count_i(rxc), .tx_trigger_i(txt), .rx_trigger_i(rxt),
    .tx_busy_i(busy), .tx_write_i(twr), .rx_read_i(rrd), .start_bit_i(sbit),
    .other_irq_i(oirq), .modem_status_read_i(mrd), .core_tx_serial_i(ctx),
    .rx_pin_i(rxp), .cts_n_i(mdm_n[0]), .dsr_n_i(mdm_n[1]),
    .carrier_detect_in_n_i(mdm_n[3]), .bell_input_n_i(mdm_n[2]), .tx_pin_o(txp),
    .rts_n_o(rts_n), .dtr_n_o(dtr_n), .user_output_one_n_o(u1_n),
    .user_output_two_n_o(u2_n), .core_rx_serial_o(crx), .tick16_o(t16), .bit_tick_o(btk),
    .modem_status_reg_o(modem_status_reg), .line_status_reg_o(line_status_reg), .irq_o(irq), .sleeping_o(slp));
  uaux_remote #(.BIT_CLKS(4)) i_remote (.clock_i(clock_i), .send_i(send), .byte_i(8'ha5),
    .modem_i(mdm), .rx_pin_o(rxp), .modem_n_o(mdm_n), .busy_o(rbusy));
  ////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // read between edges so updates have landed
  task automatic look(input int n);
    step(n);
    @(negedge clock_i);
  endtask
  // first pass finds a pulse, second counts the gap
  task automatic gap(input logic bt, output logic [15:0] n);
    repeat (2) begin
      n = 16'h0000;
      do begin
        @(negedge clock_i);
        n++;
      end while ((bt ? btk : t16) !== 1'b1 && n < 16'h2000);
    end
  endtask
  // wake pulses may last one cycle, so poll each cycle
  task automatic await_slp(input logic v);
    int i = 0;
    do begin
      @(negedge clock_i);
      i++;
    end while (slp !== v && i < 12);
    check(16'(slp), 16'(v));
  endtask
  task automatic xfer(input logic lp);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      step(1);
      ctx <= 1'(8'ha5 >> i);
      look(1);
      r[i] = lp ? crx : txp;
    end
    check({8'h00, r}, 16'h00a5);
  endtask
  ////////////////////////////////////////
  task automatic t_baud();
    logic [15:0] n;
    check(16'(line_status_reg), 16'h0003);
    gap(1'b0, n);
    check(n, 16'h0003);
    gap(1'b1, n);
    check(n, 16'(3 * TICKS_PER_BIT));
    step(1);
    modem_control_reg <= 8'h80;
    gap(1'b0, n);
    check(n, 16'(3 * PRESCALE_DIV));
    step(1);
    {dh, dl, modem_control_reg} <= 24'h010200;
    gap(1'b0, n);
    check(n, 16'h0102);
    step(1);
    // strap low, divisor back to 3 with both bytes
    {pin, dh, dl, reset_n_i} <= 18'h00006;
    step(3);
    reset_n_i <= 1'b1;
    gap(1'b0, n);
    check(n, 16'(3 * PRESCALE_DIV));
    step(1);
    {pin, dh, dl, reset_n_i} <= 18'h20000;
    step(3);
    reset_n_i <= 1'b1;
    look(5);
    check(16'(t16), 16'h0000);
  endtask
  task automatic t_irq();
    logic [44:0] tab [7] = '{{8'h01, 8'h01, 7'h01, 7'h00, 7'h05, 7'h00, 1'b1},
      {8'h01, 8'h02, 7'h00, 7'h00, 7'h00, 7'h00, 1'b1},
      {8'h01, 8'h03, 7'h00, 7'h00, 7'h05, 7'h00, 1'b0},
      {8'h09, 8'h01, 7'h09, 7'h08, 7'h00, 7'h00, 1'b1},
      {8'h09, 8'h03, 7'h08, 7'h08, 7'h04, 7'h04, 1'b0},
      {8'h09, 8'h02, 7'h00, 7'h00, 7'h03, 7'h04, 1'b1},
      {8'h09, 8'h02, 7'h09, 7'h08, 7'h04, 7'h04, 1'b0}};
    foreach (tab[i]) begin
      step(1);
      {fifo_control_reg, interrupt_enable_reg, rxc, rxt, txc, txt} <= tab[i][44:1];
      look(2);
      check(16'(irq), 16'(tab[i][0]));
    end
    step(1);
    // fifo on, five queued and shifting: room but not empty
    {fifo_control_reg, interrupt_enable_reg, rxc, txc, busy} <= 31'h0080000b;
    look(2);
    check(16'(line_status_reg), 16'h0001);
    step(1);
    {txc, busy} <= 8'h00;
  endtask
  task automatic t_sleep();
    step(1);
    enhanced_feature_reg <= 8'h10;
    look(4);
    check(16'(slp), 16'h0000);
    step(1);
    interrupt_enable_reg <= 8'h10;
    await_slp(1'b1);
    step(1);
    twr <= 1'b1;
    step(1);
    twr <= 1'b0;
    await_slp(1'b0);
    await_slp(1'b1);
    step(1);
    send <= 1'b1;
    step(1);
    send <= 1'b0;
    await_slp(1'b0);
    for (int i = 0; i < 80 && rbusy; i++) step(1);
    await_slp(1'b1);
    step(1);
    sbit <= 1'b1;
    step(1);
    sbit <= 1'b0;
    await_slp(1'b0);
    await_slp(1'b1);
    step(1);
    rrd <= 1'b1;
    step(1);
    rrd <= 1'b0;
    await_slp(1'b0);
    await_slp(1'b1);
    // a modem pin level change wakes it and shows in the level bits
    step(1);
    mdm <= 4'h1;
    await_slp(1'b0);
    await_slp(1'b1);
    check(16'(modem_status_reg), 16'h0011);
    step(1);
    oirq <= 1'b1;
    await_slp(1'b0);
    look(4);
    check(16'(slp), 16'h0000);
    step(1);
    oirq <= 1'b0;
    await_slp(1'b1);
    step(1);
    interrupt_enable_reg <= 8'h00;
    await_slp(1'b0);
  endtask
  task automatic t_loop();
    step(1);
    {modem_control_reg, interrupt_enable_reg} <= 16'h1008;
    for (int i = 0; i < 4; i++) begin
      step(5);
      mrd <= 1'b1;
      step(1);
      {mrd, modem_control_reg} <= {1'b0, 8'h10 | (8'h01 << i)};
      look(4);
      check(16'(modem_status_reg), 16'h0001 << i);
      check(16'(irq), 16'h0001);
      check({txp, rts_n, dtr_n, u1_n, u2_n}, 16'h001f);
      step(1);
      modem_control_reg <= 8'h10;
    end
    xfer(1'b1);
    step(1);
    {modem_control_reg, interrupt_enable_reg} <= 16'h0300;
    look(4);
    check({rts_n, dtr_n, u1_n, u2_n}, 16'h0003);
    xfer(1'b0);
  endtask
  ////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    step(20);
    reset_n_i <= 1'b1;
    look(2);
    t_baud();
    t_irq();
    t_sleep();
    t_loop();
    test_done();
  end
  // cut a hang well past the expected run
  initial begin
    step(20000);
    n_errors++;
    test_done();
  end
endmodule
